// >>> verilog/daq_io_ctrl.sv
// Host-visible control and status of the analog acquisition card.
// Assumes all inputs synchronous to CLK and one host request per cycle.
`timescale 1ns/1ps
`include "daq_consts.svh"

module daq_io_ctrl (
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    input  wire logic             CE,
    input  wire daq_pkg::daq_req_s HOST_REQ,
    output logic [15:0]           HOST_RDATA,
    output logic                  HOST_RVALID,
    input  wire logic             OSC_10MHZ,
    input  wire logic             EXT_PACER,
    input  wire logic [1:0]       INPUT_PACER_SOURCE,
    input  wire logic             ARM_IN,
    input  wire logic             OUT_FIFO_EMPTY,
    input  wire logic [15:0]      ADC_RESULT,
    input  wire logic             ADC_RESULT_VALID,
    output daq_pkg::daq_cal_s     CAL_CTRL,
    output daq_pkg::daq_out_s     OUT_CTRL,
    output logic                  OUTPUT_FIFO_EMPTY_LATCHED,
    output logic                  EOC_STATUS,
    output logic                  INPUT_FIFO_NOT_EMPTY_IRQ,
    output logic                  CONV_START,
    output logic                  ACQ_STOP
);
    import daq_pkg::*;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic logic hit(input daq_req_s r, input daq_region_e reg_region, input logic [3:0] ofs);
        hit = (r.region == reg_region) && (r.addr == ofs);
    endfunction

    wire cal_wr   = HOST_REQ.wr && hit(HOST_REQ, DAQ_REG_CONTROL, `DAQ_OFS_CAL);
    wire out_wr   = HOST_REQ.wr && hit(HOST_REQ, DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL);
    wire out_rd   = HOST_REQ.rd && hit(HOST_REQ, DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL);
    wire res_wr   = HOST_REQ.wr && hit(HOST_REQ, DAQ_REG_DATA, `DAQ_OFS_RESULT);
    wire res_rd   = HOST_REQ.rd && hit(HOST_REQ, DAQ_REG_DATA, `DAQ_OFS_RESULT);
    wire clr_wr   = HOST_REQ.wr && hit(HOST_REQ, DAQ_REG_DATA, `DAQ_OFS_FIFO_CLR);
    // Wider accesses to the counter region are dropped silently
    wire ctr_acc  = (HOST_REQ.region == DAQ_REG_COUNTER) && HOST_REQ.byte_acc;
    wire ctrl_wr  = ctr_acc && HOST_REQ.wr && (HOST_REQ.addr == `DAQ_OFS_CTR_CTRL);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [`DAQ_FIFO_AW-1:0] wr_ptr;
    logic [`DAQ_FIFO_AW-1:0] rd_ptr;
    logic [`DAQ_FIFO_AW:0]   fifo_count;
    logic [15:0]             mem_q;
    logic                    osc_prev;
    logic                    ext_prev;
    logic [7:0]              ctr_rdata [0:`DAQ_NUM_CTR-1];
    logic                    ctr_out   [0:`DAQ_NUM_CTR-1];
    logic                    ctr_pulse [0:`DAQ_NUM_CTR-1];
    logic                    ctr_tick  [0:`DAQ_NUM_CTR-1];
    logic                    ctr_gate  [0:`DAQ_NUM_CTR-1];

    // ---------------------------------------------------------------
    // Calibration register
    // ---------------------------------------------------------------
    // Write only; fields drive the reference mux, route switch and trim stream
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CAL_CTRL <= `DAQ_RST_CAL;
        end else if (CE && cal_wr) begin
            CAL_CTRL <= HOST_REQ.wdata;
        end
    end

    // ---------------------------------------------------------------
    // Output control and latched empty status
    // ---------------------------------------------------------------
    wire fifo_fed    = OUT_CTRL.start && (OUT_CTRL.fast_mode != 2'h0);
    wire empty_set   = fifo_fed && OUT_FIFO_EMPTY;
    wire empty_clr   = out_wr && HOST_REQ.wdata[`DAQ_BIT_EMPTY_CLR];
    // Set wins over a clear in the same cycle so no underrun is missed
    wire next_empty  = empty_set || (OUTPUT_FIFO_EMPTY_LATCHED && !empty_clr);
    wire [10:0] wr_out = {HOST_REQ.wdata[11:8], 1'b0, HOST_REQ.wdata[6:1]};

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            OUT_CTRL <= `DAQ_RST_OUT;
        end else if (CE && out_wr) begin
            OUT_CTRL <= wr_out;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            OUTPUT_FIFO_EMPTY_LATCHED <= 1'b0;
        end else if (CE) begin
            OUTPUT_FIFO_EMPTY_LATCHED <= next_empty;
        end
    end

    // ---------------------------------------------------------------
    // Pacer and residual sample counters
    // ---------------------------------------------------------------
    wire osc_rise = OSC_10MHZ && !osc_prev;
    wire ext_rise = EXT_PACER && !ext_prev;

    // Counter 0 counts conversions, 1 divides the oscillator, 2 divides counter 1
    assign ctr_tick[0] = CONV_START;
    assign ctr_tick[1] = osc_rise;
    assign ctr_tick[2] = ctr_pulse[1];
    assign ctr_gate[0] = ARM_IN;
    assign ctr_gate[1] = 1'b1;
    assign ctr_gate[2] = 1'b1;

    genvar gi;
    generate
        for (gi = 0; gi < `DAQ_NUM_CTR; gi = gi + 1) begin : g_ctr
            wire sel_ctrl = ctrl_wr && (HOST_REQ.wdata[`DAQ_CTR_SEL_HI:`DAQ_CTR_SEL_LO] == 2'(gi));
            wire data_hit = ctr_acc && (HOST_REQ.addr == 4'(gi));
            daq_counter u_ctr (
                .clk       (CLK),
                .reset_n   (RESET_N),
                .ce        (CE),
                .ctrl_wr   (sel_ctrl),
                .ctrl_data (HOST_REQ.wdata[7:0]),
                .data_wr   (data_hit && HOST_REQ.wr),
                .data_rd   (data_hit && HOST_REQ.rd),
                .wdata     (HOST_REQ.wdata[7:0]),
                .tick      (ctr_tick[gi]),
                .gate      (ctr_gate[gi]),
                .out       (ctr_out[gi]),
                .pulse     (ctr_pulse[gi]),
                .rdata     (ctr_rdata[gi])
            );
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            osc_prev <= 1'b0;
            ext_prev <= 1'b0;
        end else if (CE) begin
            osc_prev <= OSC_10MHZ;
            ext_prev <= EXT_PACER;
        end
    end

    // ---------------------------------------------------------------
    // Conversion start
    // ---------------------------------------------------------------
    // Software writes are refused unless the software source is selected
    wire sw_conv   = res_wr && (INPUT_PACER_SOURCE == `DAQ_SRC_SOFTWARE);
    wire pace_conv = (INPUT_PACER_SOURCE == `DAQ_SRC_INTERNAL) && ctr_pulse[2];
    wire ext_conv  = INPUT_PACER_SOURCE[1] && ext_rise;
    wire conv_req  = (sw_conv || pace_conv || ext_conv) && !ACQ_STOP;
    wire next_eoc  = ADC_RESULT_VALID || (EOC_STATUS && !conv_req);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            CONV_START <= 1'b0;
            ACQ_STOP   <= 1'b0;
            EOC_STATUS <= 1'b0;
        end else if (CE) begin
            CONV_START <= conv_req;
            ACQ_STOP   <= ARM_IN && ctr_out[0];
            EOC_STATUS <= next_eoc;
        end
    end

    // ---------------------------------------------------------------
    // Input result FIFO
    // ---------------------------------------------------------------
    wire push = ADC_RESULT_VALID && (fifo_count != `DAQ_FIFO_DEPTH);
    wire pop  = res_rd && (fifo_count != 10'h000);
    wire [`DAQ_FIFO_AW:0] next_count = fifo_count + {9'h000, push} - {9'h000, pop};

    daq_fifo_mem u_mem (
        .clk     (CLK),
        .ce      (CE),
        .wr_en   (push && !clr_wr),
        .wr_addr (wr_ptr),
        .wr_data (ADC_RESULT),
        .rd_addr (rd_ptr),
        .rd_data (mem_q)
    );

    // Clear takes priority; a result arriving with the clear is dropped
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wr_ptr     <= 9'h000;
            rd_ptr     <= 9'h000;
            fifo_count <= 10'h000;
        end else if (CE && clr_wr) begin
            wr_ptr     <= 9'h000;
            rd_ptr     <= 9'h000;
            fifo_count <= 10'h000;
        end else if (CE) begin
            wr_ptr     <= wr_ptr + {8'h00, push};
            rd_ptr     <= rd_ptr + {8'h00, pop};
            fifo_count <= next_count;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            INPUT_FIFO_NOT_EMPTY_IRQ <= 1'b0;
        end else if (CE) begin
            INPUT_FIFO_NOT_EMPTY_IRQ <= (fifo_count != 10'h000);
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    wire ctr_rd = ctr_acc && HOST_REQ.rd && (HOST_REQ.addr < `DAQ_OFS_CTR_CTRL);
    wire [15:0] ctr_word = ctr_rd ? {8'h00, ctr_rdata[HOST_REQ.addr[1:0]]} : 16'h0000;
    wire [15:0] rd_mux = out_rd ? {15'h0000, OUTPUT_FIFO_EMPTY_LATCHED} :
                         pop    ? mem_q : ctr_word;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            HOST_RDATA  <= 16'h0000;
            HOST_RVALID <= 1'b0;
        end else if (CE) begin
            HOST_RDATA  <= rd_mux;
            HOST_RVALID <= HOST_REQ.rd;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    cal_source_a: assert property (CE && cal_wr |=> CAL_CTRL.source_select == $past(HOST_REQ.wdata[13:11]))
        else $error("calibration source not taken from write");
    cal_route_a: assert property (CE && cal_wr ##1 !(CE && cal_wr) |=> $stable(CAL_CTRL.route_enable))
        else $error("route enable changed without a write");
    trim_stream_a: assert property (CE && cal_wr |=> CAL_CTRL.serial_bit == $past(HOST_REQ.wdata[15]))
        else $error("trim serial bit not driven from write");
    empty_clear_a: assert property (CE && empty_clr && !empty_set |=> !OUTPUT_FIFO_EMPTY_LATCHED)
        else $error("empty latch not cleared");
    empty_hold_a: assert property (OUTPUT_FIFO_EMPTY_LATCHED && !(CE && empty_clr) |=> OUTPUT_FIFO_EMPTY_LATCHED)
        else $error("empty latch dropped without clear");
    out_enable_a: assert property (CE && out_wr |=> OUT_CTRL.enable == $past(HOST_REQ.wdata[1]))
        else $error("output enable not taken from write");
    sw_conv_a: assert property (CE && res_wr && INPUT_PACER_SOURCE == 2'h0 && !ACQ_STOP |=> CONV_START)
        else $error("software write did not start a conversion");
    eoc_set_a: assert property (CE && ADC_RESULT_VALID |=> EOC_STATUS)
        else $error("end of conversion not flagged");
    irq_raise_a: assert property (CE && push && !pop && !clr_wr ##1 CE |=> INPUT_FIFO_NOT_EMPTY_IRQ)
        else $error("not-empty interrupt not raised two cycles after result");
    fifo_clear_a: assert property (CE && clr_wr ##1 CE |=> !INPUT_FIFO_NOT_EMPTY_IRQ)
        else $error("FIFO clear did not empty the FIFO");
    stop_blocks_a: assert property (CE && ACQ_STOP |=> !CONV_START)
        else $error("conversion started while acquisition stopped");

endmodule

// >>> pkg/daq_consts.svh
// Offsets, field positions, reset values and sizes of the acquisition control block.
// Assumes inclusion by bare name from the design files.
`ifndef DAQ_CONSTS_SVH
`define DAQ_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets within each region
// ---------------------------------------------------------------
`define DAQ_OFS_CAL        4'h6
`define DAQ_OFS_OUT_CTRL   4'h8
`define DAQ_OFS_RESULT     4'h0
`define DAQ_OFS_FIFO_CLR   4'h2
`define DAQ_OFS_CTR_CTRL   4'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DAQ_BIT_EMPTY_CLR  0
`define DAQ_CTR_SEL_HI     7
`define DAQ_CTR_SEL_LO     6
`define DAQ_CTR_MODE_HI    3
`define DAQ_CTR_MODE_LO    1

// ---------------------------------------------------------------
// Reset values, codes and sizes
// ---------------------------------------------------------------
`define DAQ_RST_CAL        16'h0000
`define DAQ_RST_OUT        11'h000
`define DAQ_SRC_SOFTWARE   2'h0
`define DAQ_SRC_INTERNAL   2'h1
`define DAQ_MODE_ONESHOT   3'h0
`define DAQ_FIFO_AW        9
`define DAQ_FIFO_DEPTH     10'h200
`define DAQ_WORD_W         16
`define DAQ_NUM_CTR        3

`endif

// >>> pkg/daq_pkg.sv
// Types shared by the acquisition control block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package daq_pkg;

    // ---------------------------------------------------------------
    // Host access
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        DAQ_REG_CONTROL,
        DAQ_REG_DATA,
        DAQ_REG_COUNTER,
        DAQ_REG_NONE
    } daq_region_e;

    typedef struct packed {
        daq_region_e region;
        logic [3:0]  addr;
        logic        wr;
        logic        rd;
        logic        byte_acc;
        logic [15:0] wdata;
    } daq_req_s;

    // ---------------------------------------------------------------
    // Register layouts, msb first
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       serial_bit;
        logic       route_enable;
        logic [2:0] source_select;
        logic       offset_conv_en;
        logic       potentiometer_select;
        logic       trim_converter_select;
        logic [7:0] offset_code;
    } daq_cal_s;

    typedef struct packed {
        logic [1:0] range1;
        logic [1:0] range0;
        logic       unused7;
        logic [1:0] fast_mode;
        logic [1:0] pacer_source;
        logic       start;
        logic       enable;
    } daq_out_s;

endpackage

// >>> verilog/daq_fifo_mem.sv
// Word store of the input result FIFO.
// Assumes the caller keeps pointers; read data is registered, one cycle late.
`timescale 1ns/1ps
`include "daq_consts.svh"

module daq_fifo_mem (
    input  wire logic                      clk,
    input  wire logic                      ce,
    input  wire logic                      wr_en,
    input  wire logic [`DAQ_FIFO_AW-1:0]   wr_addr,
    input  wire logic [`DAQ_WORD_W-1:0]    wr_data,
    input  wire logic [`DAQ_FIFO_AW-1:0]   rd_addr,
    output logic      [`DAQ_WORD_W-1:0]    rd_data
);

    logic [`DAQ_WORD_W-1:0] mem [0:(1<<`DAQ_FIFO_AW)-1];

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    // No reset on the array; rd_data is defined once a word is stored
    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// >>> verilog/daq_counter.sv
// One 16-bit counter of the pacer and sample counter group.
// Assumes tick and gate are one-cycle CLK-domain qualifiers.
`timescale 1ns/1ps
`include "daq_consts.svh"

module daq_counter (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_data,
    input  wire logic       data_wr,
    input  wire logic       data_rd,
    input  wire logic [7:0] wdata,
    input  wire logic       tick,
    input  wire logic       gate,
    output logic            out,
    output logic            pulse,
    output logic [7:0]      rdata
);

    logic [2:0]  mode;
    logic [15:0] cnt;
    logic [15:0] reload;
    logic [7:0]  low_byte;
    logic        hi_phase;
    logic        rd_phase;
    logic        armed;

    wire step     = armed && gate && tick;
    wire terminal = step && (cnt == 16'h0001);
    wire oneshot  = (mode == `DAQ_MODE_ONESHOT);
    wire [15:0] next_cnt = (terminal && !oneshot) ? reload : cnt - 16'h0001;
    assign rdata = rd_phase ? cnt[15:8] : cnt[7:0];

    // ---------------------------------------------------------------
    // Mode and count loading
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode     <= `DAQ_MODE_ONESHOT;
            low_byte <= 8'h00;
            hi_phase <= 1'b0;
            armed    <= 1'b0;
            reload   <= 16'h0000;
        end else if (ce) begin
            if (ctrl_wr) begin
                mode     <= ctrl_data[`DAQ_CTR_MODE_HI:`DAQ_CTR_MODE_LO];
                hi_phase <= 1'b0;
                armed    <= 1'b0;
            end else if (data_wr && !hi_phase) begin
                low_byte <= wdata;
                hi_phase <= 1'b1;
            end else if (data_wr) begin
                reload   <= {wdata, low_byte};
                hi_phase <= 1'b0;
                armed    <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Counting
    // ---------------------------------------------------------------
    // Mode 0 keeps counting past zero but its output stays high
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt      <= 16'h0000;
            out      <= 1'b0;
            pulse    <= 1'b0;
            rd_phase <= 1'b0;
        end else if (ce) begin
            pulse <= terminal;
            if (ctrl_wr) begin
                out      <= !(ctrl_data[`DAQ_CTR_MODE_HI:`DAQ_CTR_MODE_LO] == `DAQ_MODE_ONESHOT);
                rd_phase <= 1'b0;
            end else if (data_wr && hi_phase) begin
                cnt <= {wdata, low_byte};
                out <= !oneshot;
            end else if (step) begin
                cnt <= next_cnt;
                if (terminal && oneshot) begin
                    out <= 1'b1;
                end
            end
            if (data_rd && !ctrl_wr) begin
                rd_phase <= ~rd_phase;
            end
        end
    end

endmodule

// >>> tb/daq_adc_model.sv
// Behavioural input converter facing the conversion start and result ports.
// Assumes the bench supplies the next result word and the answer speed.
`timescale 1ns/1ps

module daq_adc_model (
    input  wire logic        clk,
    input  wire logic        conv_start,
    input  wire logic        slow,
    input  wire logic [15:0] word,
    output logic      [15:0] result,
    output logic             valid
);
    // ---------------------------------------------------------------
    // Conversion timing
    // ---------------------------------------------------------------
    logic [3:0] cnt = 4'h0;
    logic       busy = 1'b0;
    initial begin
        valid = 1'b0;
        result = 16'hA5A5;
    end
    // Result toggles outside valid, so a stale word never looks right
    always @(posedge clk) begin
        valid <= 1'b0;
        result <= ~result;
        if (conv_start) begin
            busy <= 1'b1;
            cnt <= slow ? 4'hC : 4'h1;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            valid <= 1'b1;
            result <= word;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// >>> tb/daq_io_ctrl_tb.sv
// Self-checking bench of the acquisition control block.
// Assumes the design package, constants header and converter model.
`timescale 1ns/1ps
`include "daq_consts.svh"

module daq_io_ctrl_tb;
    import daq_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic        clk, reset_n, arm, empty, slow, rvalid, lat, eoc, irq, cstart, stop, res_v, osc;
    logic [1:0]  src;
    logic [15:0] q, w, adc_word, rdata, res;
    daq_req_s    req;
    daq_cal_s    cal;
    daq_out_s    outc;
    int          mismatches, comparisons, i, n;

    daq_io_ctrl u_daq_io_ctrl (.CLK(clk), .RESET_N(reset_n), .CE(1'b1), .HOST_REQ(req), .HOST_RDATA(rdata),
        .HOST_RVALID(rvalid), .OSC_10MHZ(osc), .EXT_PACER(1'b0), .INPUT_PACER_SOURCE(src), .ARM_IN(arm),
        .OUT_FIFO_EMPTY(empty), .ADC_RESULT(res), .ADC_RESULT_VALID(res_v), .CAL_CTRL(cal), .OUT_CTRL(outc),
        .OUTPUT_FIFO_EMPTY_LATCHED(lat), .EOC_STATUS(eoc), .INPUT_FIFO_NOT_EMPTY_IRQ(irq),
        .CONV_START(cstart), .ACQ_STOP(stop));
    daq_adc_model u_daq_adc_model (.clk(clk), .conv_start(cstart), .slow(slow), .word(adc_word),
        .result(res), .valid(res_v));

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] out_exp(input logic [15:0] v);
        return {5'h00, v[11:8], 1'b0, v[6:1]};
    endfunction
    // Request held for one taking edge; read data picked up just after it
    task automatic acc(input daq_region_e r, input logic [3:0] a, input logic wr, input logic b,
                       input logic [15:0] d);
        @(posedge clk);
        req <= '{r, a, wr, !wr, b, d};
        @(posedge clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1;
        q = rdata;
        chk(16'(rvalid), 16'(!wr));
    endtask
    task automatic conv(input logic [15:0] word, input logic s);
        adc_word = word;
        slow = s;
        acc(DAQ_REG_DATA, `DAQ_OFS_RESULT, 1'b1, 1'b0, 16'h0);
        chk(16'(cstart), 16'h1);
        n = 0;
        while (eoc !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 50) begin
            mismatches++;
            stop_test();
        end
        @(posedge clk);
        #1;
        chk(16'(irq), 16'h1);
    endtask

    // ---------------------------------------------------------------
    // Stimulus
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {reset_n, arm, empty, slow, src, adc_word, osc} = '0;
        req = '0;
        mismatches = 0;
        comparisons = 0;
        void'($urandom(22));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        for (i = 0; i < 6; i++) begin
            w = i == 0 ? 16'hFFFF : 16'($urandom);
            acc(DAQ_REG_CONTROL, `DAQ_OFS_CAL, 1'b1, 1'b0, w);
            chk(16'(cal), w);
            w[0] = 1'b0;
            acc(DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL, 1'b1, 1'b0, w);
            chk(16'(outc), out_exp(w));
            acc(DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL, 1'b0, 1'b0, 16'h0);
            chk(q, 16'h0);
        end
        acc(DAQ_REG_CONTROL, 4'hF, 1'b0, 1'b0, 16'h0);
        chk(q, 16'h0);
        // Underrun while FIFO-fed output runs on converter 0
        acc(DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL, 1'b1, 1'b0, 16'h0026);
        empty <= 1'b1;
        @(posedge clk);
        empty <= 1'b0;
        acc(DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL, 1'b0, 1'b0, 16'h0);
        chk(q, 16'h1);
        acc(DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL, 1'b1, 1'b0, 16'h0022);
        chk(16'(lat), 16'h1);
        acc(DAQ_REG_CONTROL, `DAQ_OFS_OUT_CTRL, 1'b1, 1'b0, 16'h0023);
        chk(16'(lat), 16'h0);
        acc(DAQ_REG_DATA, `DAQ_OFS_FIFO_CLR, 1'b1, 1'b0, 16'($urandom));
        for (i = 0; i < 4; i++) begin
            w = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($urandom);
            conv(w, i[0]);
            acc(DAQ_REG_DATA, `DAQ_OFS_RESULT, 1'b0, 1'b0, 16'h0);
            chk(q, w);
        end
        src <= 2'b10;
        acc(DAQ_REG_DATA, `DAQ_OFS_RESULT, 1'b1, 1'b0, 16'h0);
        chk(16'(cstart), 16'h0);
        src <= 2'b00;
        conv(16'h1234, 1'b0);
        conv(16'h4321, 1'b1);
        acc(DAQ_REG_DATA, `DAQ_OFS_FIFO_CLR, 1'b1, 1'b0, 16'($urandom));
        @(posedge clk);
        #1;
        chk(16'(irq), 16'h0);
        acc(DAQ_REG_DATA, `DAQ_OFS_RESULT, 1'b0, 1'b0, 16'h0);
        chk(q, 16'h0);
        // Residual counter: word access refused, then count of two
        acc(DAQ_REG_COUNTER, 4'h0, 1'b0, 1'b0, 16'h0);
        chk(q, 16'h0);
        acc(DAQ_REG_COUNTER, `DAQ_OFS_CTR_CTRL, 1'b1, 1'b1, 16'h0030);
        acc(DAQ_REG_COUNTER, 4'h0, 1'b1, 1'b1, 16'h0002);
        acc(DAQ_REG_COUNTER, 4'h0, 1'b1, 1'b1, 16'h0000);
        arm <= 1'b1;
        conv(16'($urandom), 1'b0);
        chk(16'(stop), 16'h0);
        conv(16'($urandom), 1'b0);
        chk(16'(stop), 16'h1);
        acc(DAQ_REG_DATA, `DAQ_OFS_RESULT, 1'b1, 1'b0, 16'h0);
        chk(16'(cstart), 16'h0);
        // Internal pacer: both dividers in rate-generator mode, count of two each
        arm <= 1'b0;
        src <= 2'b01;
        acc(DAQ_REG_COUNTER, `DAQ_OFS_CTR_CTRL, 1'b1, 1'b1, 16'h0044);
        acc(DAQ_REG_COUNTER, 4'h1, 1'b1, 1'b1, 16'h0002);
        acc(DAQ_REG_COUNTER, 4'h1, 1'b1, 1'b1, 16'h0000);
        acc(DAQ_REG_COUNTER, `DAQ_OFS_CTR_CTRL, 1'b1, 1'b1, 16'h0084);
        acc(DAQ_REG_COUNTER, 4'h2, 1'b1, 1'b1, 16'h0002);
        acc(DAQ_REG_COUNTER, 4'h2, 1'b1, 1'b1, 16'h0000);
        n = 0;
        while (cstart !== 1'b1 && n < 100) begin
            @(posedge clk);
            osc <= ~osc;
            #1;
            n++;
        end
        chk(16'(cstart), 16'h1);
        stop_test();
    end
endmodule
